// ===== uers_regs.sv
// endpoint register set: apb registers, fifos, flags, hub change byte
// ------------------------------------------------------------
// Behaviour
// R1 - bit 7 enables endpoint, resets off
// R2 - data toggle flips in hardware
// R3 - bit 2 direction: 0 out, 1 in
// R4 - firmware sets endpoint-zero type to 00
// R5 - type codes: 01 iso, 10 bulk, 11 interrupt
// R6 - reserved bits read zero
// R7 - fifo port moves one byte per access; the code drops the access when usb writes or reads that fifo in the same cycle
// R8 - hub change byte hardware-updated, firmware-invisible
// R9 - hub bit 0, ports bits 1-5
// R10 - byte count includes two crc bytes
// R11 - packets at most 8 bytes
// R12 - count bits 4:0 writable, bit 5 read-only
// R13 - halt-sent set on stall, write-one clears
// R14 - setup-received clears all other flags
// R15 - setup-received interrupts when enabled
// R16 - out-received flag makes out tokens nak
// R17 - full fifo kept except early setup
// R18 - out flag for data and status out
// R19 - out-received interrupts, write-one clears
// R20 - transmit-done on in stage completion
// R21 - transmit-done cleared only by clear bit; the code also clears it on setup-received (R14)
// R22 - clear bits are one-shot, never stored
// R23 - transmit-ready cleared on host ack
// R24 - flags kept separately per endpoint
// R25 - all registers reset to zero
// ------------------------------------------------------------
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module uers_regs
	import uers_pkg::*;
(
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	// apb slave
	input  wire uers_apb_req_t             apb_req,
	output uers_apb_rsp_t                  apb_rsp,
	// usb packet engine
	input  wire uers_evt_t                 usb_evt,
	output logic         [7:0]             tx_byte,
	output uers_ep_cfg_t [NUM_EP-1:0]      ep_cfg,
	output logic         [NUM_EP-1:0]      ep_out_nak,
	output logic         [NUM_EP-1:0]      ep_tx_ready,
	// hub status change
	input  wire logic    [5:0]             hub_change_in,
	output logic         [7:0]             hub_change_byte,
	// firmware attention
	output logic                           fw_irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [NUM_EP-1:0][7:0]       cfg;
		logic [NUM_EP-1:0][LEN_W-1:0] len;
		logic [NUM_EP-1:0][3:0]       flg;
		logic [NUM_EP-1:0]            txrdy;
		logic [3:0]                   irq_en;
		logic [5:0]                   chg;
	} uers_st_t;

	uers_st_t                     st_q;
	uers_st_t                     st_d;

	logic [IDX_W-1:0]             idx;
	logic                         acc;
	logic                         wr_acc;
	logic                         rd_acc;
	logic [NUM_EP-1:0]            sel_cfg;
	logic [NUM_EP-1:0]            sel_len;
	logic [NUM_EP-1:0]            sel_fifo;
	logic [NUM_EP-1:0]            sel_flg;
	logic [NUM_EP-1:0]            sel_clr;
	logic                         sel_txr;
	logic                         sel_irq;
	logic                         mapped;
	logic [7:0]                   rd_val;
	logic [NUM_EP-1:0][3:0]       flg_clr;
	logic [NUM_EP-1:0]            ev_hit;
	logic [NUM_EP-1:0]            ev_setup;
	logic [NUM_EP-1:0]            ev_out;
	logic [NUM_EP-1:0]            ev_in;
	logic [NUM_EP-1:0]            ev_stall;
	logic [NUM_EP-1:0]            fifo_open;
	logic [NUM_EP-1:0][7:0]       fifo_rdata;
	logic [LEN_W-1:0]             rx_len_sat;
	logic [NUM_EP-1:0]            irq_vec;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	assign idx    = apb_req.paddr[ADDR_W-1:2];
	assign acc    = apb_req.psel && apb_req.penable;
	assign wr_acc = acc && apb_req.pwrite;
	assign rd_acc = acc && !apb_req.pwrite;

	always_comb begin
		sel_txr = (idx == IDX_TXRDY);
		sel_irq = (idx == IDX_IRQ_EN);
		rd_val  = 8'h00;
		if (sel_txr) rd_val = {3'b000, st_q.txrdy};
		if (sel_irq) rd_val = {4'h0, st_q.irq_en};
		for (int e = 0; e < NUM_EP; e++) begin
			sel_cfg[e]  = (idx == IDX_CFG[e]);
			sel_len[e]  = (idx == IDX_LEN[e]);
			sel_fifo[e] = (idx == IDX_FIFO[e]);
			sel_flg[e]  = FLG_MAP[e] && (idx == IDX_FLG[e]);
			sel_clr[e]  = (idx == IDX_CLR[e]);
			flg_clr[e]  = (wr_acc && sel_clr[e]) ?
				apb_req.pwdata[3:0] : 4'h0;               // [R22]
			if (sel_cfg[e])
				rd_val = st_q.cfg[e] & CFG_RW_MASK;       // [R6]
			if (sel_len[e])
				rd_val = {2'b00, st_q.len[e]};            // [R6]
			if (sel_fifo[e])
				rd_val = fifo_rdata[e];                   // [R7]
			if (sel_flg[e])
				rd_val = {4'h0, st_q.flg[e]};             // [R6]
		end
		mapped = |{sel_cfg, sel_len, sel_fifo, sel_flg, sel_clr,
			sel_txr, sel_irq};
	end

	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = acc && !mapped;
	assign apb_rsp.prdata  = {24'h00_0000, rd_val};

	// ------------------------------------------------------------
	// usb event qualification
	// ------------------------------------------------------------
	assign rx_len_sat = (usb_evt.rx_len > MAX_COUNT) ?
		MAX_COUNT : usb_evt.rx_len;                           // [R11]

	always_comb begin
		for (int e = 0; e < NUM_EP; e++) begin
			ev_hit[e] = (usb_evt.ep == 3'(e)) &&
				st_q.cfg[e][ENDPOINT_ON_BIT];                 // [R1] [R24]
			ev_setup[e] = ev_hit[e] && usb_evt.setup_rx &&
				(st_q.cfg[e][1:0] == EPT_CTRL);
			ev_out[e] = ev_hit[e] && usb_evt.out_rx &&
				!st_q.flg[e][FLG_OUT];                        // [R16] [R18]
			ev_in[e]     = ev_hit[e] && usb_evt.in_ack;
			ev_stall[e]  = ev_hit[e] && usb_evt.stall_sent;
			fifo_open[e] = ev_hit[e] &&
				(usb_evt.setup_pkt || !st_q.flg[e][FLG_OUT]); // [R17]
			irq_vec[e]   = |(st_q.flg[e] & st_q.irq_en);      // [R15] [R19]
		end
	end

	// ------------------------------------------------------------
	// endpoint fifos
	// ------------------------------------------------------------
	for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
		logic u_wr;
		logic u_rd;
		logic f_wr;
		logic f_rd;

		assign u_wr = fifo_open[g] && usb_evt.rx_wr;
		assign u_rd = ev_hit[g] && usb_evt.tx_rd;
		assign f_wr = wr_acc && sel_fifo[g] && !u_wr && !u_rd;
		assign f_rd = rd_acc && sel_fifo[g] && !u_wr && !u_rd;

		uers_ep_fifo #(
			.DEPTH (FIFO_DEPTH),
			.W     (8)
		) u_fifo (
			.core_clk (core_clk),
			.sys_rst  (sys_rst),
			.clr      (fifo_open[g] && usb_evt.pkt_start),
			.wr       (u_wr || f_wr),
			.wdata    (u_wr ? usb_evt.rx_byte : apb_req.pwdata[7:0]),
			.rd       (u_rd || f_rd),                     // [R7]
			.rdata    (fifo_rdata[g]),
			.empty    (),
			.full     ()
		);

		assign ep_cfg[g].on     = st_q.cfg[g][ENDPOINT_ON_BIT];
		assign ep_cfg[g].toggle = st_q.cfg[g][DATA_TOGGLE_BIT];
		assign ep_cfg[g].dir_in =
			st_q.cfg[g][TRANSFER_DIRECTION_BIT];               // [R3]
		assign ep_cfg[g].kind   =
			uers_ep_type_t'(st_q.cfg[g][1:0]);                 // [R5]
		assign ep_out_nak[g]    = st_q.flg[g][FLG_OUT];        // [R16]
	end

	assign tx_byte = (usb_evt.ep < 3'(NUM_EP)) ?
		fifo_rdata[usb_evt.ep] : 8'h00;
	assign ep_tx_ready     = st_q.txrdy;
	assign hub_change_byte = {2'b00, st_q.chg};               // [R9]
	assign fw_irq          = |irq_vec;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_d     = st_q;
		st_d.chg = hub_change_in;                             // [R8]
		if (wr_acc && sel_irq) st_d.irq_en = apb_req.pwdata[3:0];
		for (int e = 0; e < NUM_EP; e++) begin
			if (wr_acc && sel_cfg[e])
				st_d.cfg[e] = apb_req.pwdata[7:0] & CFG_RW_MASK; // [R1]
			if (wr_acc && sel_len[e])
				st_d.len[e] = {st_q.len[e][LEN_W-1],
					apb_req.pwdata[LEN_W-2:0]};               // [R12]
			if (wr_acc && sel_txr)
				st_d.txrdy[e] = apb_req.pwdata[e];
			if (ev_setup[e] || ev_out[e])
				st_d.len[e] = rx_len_sat;                     // [R10]
			if (ev_setup[e])
				st_d.cfg[e][DATA_TOGGLE_BIT] = 1'b1;          // [R2]
			else if (ev_in[e] || ev_out[e])
				st_d.cfg[e][DATA_TOGGLE_BIT] =
					!st_q.cfg[e][DATA_TOGGLE_BIT];            // [R2]
			if (ev_in[e])
				st_d.txrdy[e] = 1'b0;                         // [R23]
			// set wins over a clear in the same cycle
			st_d.flg[e] = st_q.flg[e] & ~flg_clr[e];          // [R21]
			if (ev_stall[e]) st_d.flg[e][FLG_STALL] = 1'b1;   // [R13]
			if (ev_out[e]) st_d.flg[e][FLG_OUT] = 1'b1;       // [R18]
			if (ev_in[e]) st_d.flg[e][FLG_TXDONE] = 1'b1;     // [R20]
			if (ev_setup[e]) st_d.flg[e] = FLG_ONLY_SETUP;    // [R14]
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '0;                                       // [R25]
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	rst_all_zero_a: assert property ( // [R25]
		$past(sys_rst) |-> (st_q == '0) && !fw_irq)
		else $error("state not zero after reset");

	unmapped_err_a: assert property (
		acc && !mapped |-> apb_rsp.pslverr && rd_val == 8'h00)
		else $error("unmapped access not flagged");

	chg_follow_a: assert property ( // [R9]
		##1 hub_change_byte == {2'b00, $past(hub_change_in)})
		else $error("hub change byte wrong");

	for (genvar a = 0; a < NUM_EP; a++) begin : g_chk
		setup_excl_a: assert property ( // [R14]
			ev_setup[a] |=> st_q.flg[a] == FLG_ONLY_SETUP
				&& st_q.cfg[a][DATA_TOGGLE_BIT])
			else $error("setup did not clear other flags");

		out_set_wins_a: assert property ( // [R19]
			ev_out[a] && !ev_setup[a] |=> st_q.flg[a][FLG_OUT]
				&& ep_out_nak[a])
			else $error("out flag lost");

		out_hold_a: assert property ( // [R17]
			st_q.flg[a][FLG_OUT] && usb_evt.out_rx && ev_hit[a]
				&& !usb_evt.setup_rx |=> $stable(st_q.len[a]))
			else $error("count overwritten while full");

		in_done_a: assert property ( // [R23]
			ev_in[a] && !ev_setup[a] |=> !st_q.txrdy[a]
				&& st_q.flg[a][FLG_TXDONE]
				&& st_q.cfg[a][DATA_TOGGLE_BIT]
					!= $past(st_q.cfg[a][DATA_TOGGLE_BIT]))
			else $error("in ack handling wrong");

		stall_flag_a: assert property ( // [R13]
			ev_stall[a] && !ev_setup[a] |=> st_q.flg[a][FLG_STALL]
				##1 st_q.flg[a][FLG_STALL] || $past(flg_clr[a][3])
				|| $past(ev_setup[a]))
			else $error("halt-sent flag not held");

		off_ignores_a: assert property ( // [R1]
			!st_q.cfg[a][ENDPOINT_ON_BIT] && flg_clr[a] == 4'h0
				|=> $stable(st_q.flg[a]))
			else $error("disabled endpoint changed flags");

		len_ro_a: assert property ( // [R12]
			wr_acc && sel_len[a] && !ev_setup[a] && !ev_out[a]
				|=> st_q.len[a][5] == $past(st_q.len[a][5])
				&& st_q.len[a][4:0] == $past(apb_req.pwdata[4:0]))
			else $error("count write wrong");

		len_limit_a: assert property ( // [R11]
			ev_setup[a] || ev_out[a] |=> st_q.len[a] <= MAX_COUNT)
			else $error("count above packet limit");

		txdone_hold_a: assert property ( // [R21]
			st_q.flg[a][FLG_TXDONE] && !flg_clr[a][FLG_TXDONE]
				&& !ev_setup[a] |=> st_q.flg[a][FLG_TXDONE])
			else $error("transmit-done lost without clear");

		out_flag_hold_a: assert property ( // [R16]
			st_q.flg[a][FLG_OUT] && !flg_clr[a][FLG_OUT]
				&& !ev_setup[a] |=> st_q.flg[a][FLG_OUT])
			else $error("out-received lost without clear");

		cfg_write_a: assert property ( // [R3]
			wr_acc && sel_cfg[a] && !ev_setup[a] && !ev_in[a]
				&& !ev_out[a] |=> st_q.cfg[a]
				== ($past(apb_req.pwdata[7:0]) & CFG_RW_MASK))
			else $error("config write wrong");

		other_ep_a: assert property ( // [R24]
			!ev_hit[a] && flg_clr[a] == 4'h0
				|=> $stable(st_q.flg[a]))
			else $error("flags changed without own event");
	end

	rsvd_zero_a: assert property ( // [R6]
		rd_acc && |sel_cfg |-> apb_rsp.prdata[6:4] == 3'b000)
		else $error("reserved bits not zero");

	clr_read_a: assert property ( // [R22]
		rd_acc && |sel_clr |-> apb_rsp.prdata == 32'h0000_0000)
		else $error("clear register not read as zero");

	irq_setup_a: assert property ( // [R15]
		|ev_setup && st_q.irq_en[FLG_SETUP] && !(wr_acc && sel_irq)
			|=> fw_irq)
		else $error("no interrupt on setup");

	irq_out_a: assert property ( // [R19]
		|ev_out && st_q.irq_en[FLG_OUT] && !(wr_acc && sel_irq)
			|=> fw_irq)
		else $error("no interrupt on out packet");

	// ------------------------------------------------------------
	// coverage
	// ------------------------------------------------------------
	cov_setup_c: cover property (|ev_setup ##[1:50] |ev_in);
	cov_out_c: cover property (|ev_out ##1 fw_irq);
	cov_stall_c: cover property (|ev_stall);
	cov_fifo_c: cover property (rd_acc && |sel_fifo);
	cov_clr_c: cover property (wr_acc && |sel_clr);

endmodule : uers_regs

// ===== uers_pkg.sv
// shared constants and carrier types for the endpoint register set
package uers_pkg;

	// ------------------------------------------------------------
	// endpoint numbering and register indices
	// ------------------------------------------------------------
	localparam int NUM_EP   = 5;
	localparam int ADDR_W   = 16;
	localparam int IDX_W    = 14;
	// element order: hub ep0, func ep0, func ep1, func ep2, func ep3
	localparam logic [NUM_EP-1:0][IDX_W-1:0] IDX_CFG = {
		14'h1fe2, 14'h1fe3, 14'h1fe4, 14'h0024, 14'h1fe7};
	localparam logic [NUM_EP-1:0][IDX_W-1:0] IDX_LEN = {
		14'h1fca, 14'h1fcb, 14'h1fcc, 14'h1fcd, 14'h1fcf};
	localparam logic [NUM_EP-1:0][IDX_W-1:0] IDX_FIFO = {
		14'h1fd2, 14'h1fd3, 14'h1fd4, 14'h1fd5, 14'h1fd7};
	localparam logic [NUM_EP-1:0][IDX_W-1:0] IDX_FLG = {
		14'h0000, 14'h0000, 14'h0000, 14'h1fdd, 14'h1fdf};
	localparam logic [NUM_EP-1:0]            FLG_MAP = 5'b0_0011;
	localparam logic [NUM_EP-1:0][IDX_W-1:0] IDX_CLR = {
		14'h1fb4, 14'h1fb3, 14'h1fb2, 14'h1fb1, 14'h1fb0};
	localparam logic [IDX_W-1:0] IDX_TXRDY  = 14'h1fa8;
	localparam logic [IDX_W-1:0] IDX_IRQ_EN = 14'h1fb8;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int ENDPOINT_ON_BIT        = 7;
	localparam int DATA_TOGGLE_BIT        = 3;
	localparam int TRANSFER_DIRECTION_BIT = 2;
	localparam logic [7:0] CFG_RW_MASK    = 8'h8f;
	localparam int LEN_W                  = 6;
	localparam int FLG_STALL              = 3;
	localparam int FLG_SETUP              = 2;
	localparam int FLG_OUT                = 1;
	localparam int FLG_TXDONE             = 0;
	localparam logic [3:0] FLG_ONLY_SETUP = 4'h4;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam int CRC_BYTES              = 2;
	localparam int MAX_PAYLOAD            = 8;
	localparam logic [LEN_W-1:0] MAX_COUNT =
		LEN_W'(MAX_PAYLOAD + CRC_BYTES);
	localparam int FIFO_DEPTH             = 8;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EPT_CTRL = 2'b00,
		EPT_ISO  = 2'b01,
		EPT_BULK = 2'b10,
		EPT_INTR = 2'b11
	} uers_ep_type_t;

	typedef struct packed {
		logic          on;
		logic          toggle;
		logic          dir_in;
		uers_ep_type_t kind;
	} uers_ep_cfg_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} uers_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} uers_apb_rsp_t;

	typedef struct packed {
		logic [2:0]       ep;
		logic             setup_pkt;
		logic             pkt_start;
		logic             rx_wr;
		logic [7:0]       rx_byte;
		logic [LEN_W-1:0] rx_len;
		logic             setup_rx;
		logic             out_rx;
		logic             in_ack;
		logic             stall_sent;
		logic             tx_rd;
	} uers_evt_t;

endpackage : uers_pkg

// ===== uers_ep_fifo.sv
// byte-wide endpoint fifo held in flip-flops
`timescale 1ns/100ps
module uers_ep_fifo
	import uers_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int W     = 8
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// control
	input  wire logic         clr,
	// write side
	input  wire logic         wr,
	input  wire logic [W-1:0] wdata,
	// read side
	input  wire logic         rd,
	output logic      [W-1:0] rdata,
	output logic              empty,
	output logic              full
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [PW:0]             cnt;
	} uers_fifo_st_t;

	uers_fifo_st_t st_q;
	uers_fifo_st_t st_d;

	assign empty = (st_q.cnt == '0);
	assign full  = (st_q.cnt == (PW+1)'(DEPTH));
	assign rdata = empty ? '0 : st_q.mem[st_q.rp];

	always_comb begin
		st_d = st_q;
		if (clr) begin
			st_d.wp  = '0;
			st_d.rp  = '0;
			st_d.cnt = '0;
		end else begin
			if (wr && !full) begin
				st_d.mem[st_q.wp] = wdata;
				st_d.wp = PW'(st_q.wp + 1'b1);
			end
			if (rd && !empty) begin
				st_d.rp = PW'(st_q.rp + 1'b1);
			end
			st_d.cnt = (PW+1)'(st_q.cnt + (PW+1)'(wr && !full)
				- (PW+1)'(rd && !empty));
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule : uers_ep_fifo

// ===== uers_usb_host.sv
// usb host model driving packet events into the endpoint register set
`timescale 1ns/100ps
module uers_usb_host
	import uers_pkg::*;
(
	// clock
	input  wire logic       core_clk,
	// head byte of the addressed fifo
	input  wire logic [7:0] tx_byte,
	// packet events toward the register set
	output uers_evt_t usb_evt
);

	initial usb_evt = '0;

	// ------------------------------------------------------------
	// packet tasks
	// ------------------------------------------------------------
	// one packet: start, n data bytes, then the setup or out event
	task automatic out_pkt(input logic [2:0] ep, input logic setup,
		input logic [7:0] b0, input int n, input logic [5:0] len);
		uers_evt_t e;
		e = '0;
		e.ep = ep;
		e.setup_pkt = setup;
		e.pkt_start = 1'b1;
		@(posedge core_clk) usb_evt <= e;
		e.pkt_start = 1'b0;
		e.rx_wr = 1'b1;
		for (int i = 0; i < n; i++) begin
			e.rx_byte = b0 + 8'(i);
			@(posedge core_clk) usb_evt <= e;
		end
		e.rx_wr = 1'b0;
		e.rx_byte = ~e.rx_byte;
		e.setup_rx = setup;
		e.out_rx = ~setup;
		e.rx_len = len;
		@(posedge core_clk) usb_evt <= e;
		e = '0;
		e.rx_byte = ~b0;
		@(posedge core_clk) usb_evt <= e;
	endtask : out_pkt

	// handshake seen on the bus: ack of an in packet or a stall sent
	task automatic ev(input logic [2:0] ep, input logic stall);
		uers_evt_t e;
		e = '0;
		e.ep = ep;
		e.in_ack = ~stall;
		e.stall_sent = stall;
		@(posedge core_clk) usb_evt <= e;
		@(posedge core_clk) usb_evt <= '0;
	endtask : ev

	// in data: pop n bytes, each taken before its own pop
	task automatic in_pkt(input logic [2:0] ep, input int n,
		output logic [63:0] got);
		uers_evt_t e;
		e = '0;
		e.ep = ep;
		e.tx_rd = 1'b1;
		got = '0;
		@(posedge core_clk) usb_evt <= e;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			got[8*i +: 8] = tx_byte;
		end
		usb_evt <= '0;
	endtask : in_pkt

endmodule : uers_usb_host

// ===== tb.sv
// self-checking testbench for the endpoint register set
`timescale 1ns/100ps
module tb
	import uers_pkg::*;
;

	logic                        core_clk    = 1'b0;
	logic                        sys_rst     = 1'b1;
	uers_apb_req_t               req         = '0;
	uers_apb_rsp_t               rsp;
	uers_evt_t                   evt;
	logic         [7:0]          tx_byte;
	logic         [7:0]          hub_byte;
	uers_ep_cfg_t [NUM_EP-1:0]   cfg;
	logic         [NUM_EP-1:0]   nak;
	logic         [NUM_EP-1:0]   txrdy;
	logic         [5:0]          hub_in      = '0;
	logic                        irq;
	logic         [31:0]         rd;
	logic                        err;
	logic         [63:0]         got;
	int                          miscompares = 0;
	int                          checks      = 0;

	always #5 core_clk = ~core_clk;

	uers_regs u_dut (
		.core_clk        (core_clk),
		.sys_rst         (sys_rst),
		.apb_req         (req),
		.apb_rsp         (rsp),
		.usb_evt         (evt),
		.tx_byte         (tx_byte),
		.ep_cfg          (cfg),
		.ep_out_nak      (nak),
		.ep_tx_ready     (txrdy),
		.hub_change_in   (hub_in),
		.hub_change_byte (hub_byte),
		.fw_irq          (irq)
	);

	uers_usb_host u_host (
		.core_clk (core_clk),
		.tx_byte  (tx_byte),
		.usb_evt  (evt)
	);

	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic stop_test;
		$display("miscompares %0d checks %0d", miscompares, checks);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [IDX_W-1:0] idx,
		input logic [7:0] d);
		int n;
		@(posedge core_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w,
			paddr: {idx, 2'b00}, pwdata: {24'h00_0000, d}};
		@(posedge core_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		if (rsp.pready !== 1'b1) begin
			miscompares++;
			stop_test();
		end
	endtask : apb

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h00_0000, e});
	endtask : rchk

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < NUM_EP; i++) begin
			rchk(IDX_CFG[i], 8'h00);
			rchk(IDX_LEN[i], 8'h00);
		end
		rchk(IDX_FLG[0], 8'h00);
		rchk(IDX_FLG[1], 8'h00);
		apb(1'b0, 14'h0100, 8'h00);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		wr(IDX_CFG[2], 8'hff);
		rchk(IDX_CFG[2], 8'h8f);
		chk({27'h000_0000, cfg[2]}, 32'h0000_001f);
		for (int i = 1; i < 4; i++) begin
			wr(IDX_CFG[i+1], 8'h80 | 8'(i));
			rchk(IDX_CFG[i+1], 8'h80 | 8'(i));
			chk({27'h000_0000, cfg[i+1]}, 32'h0000_0010 | 32'(i));
		end
		wr(IDX_LEN[0], 8'hff);
		rchk(IDX_LEN[0], 8'h1f);
		for (int i = 0; i < 3; i++)
			wr(IDX_FIFO[0], 8'h30 + 8'(i));
		for (int i = 0; i < 3; i++)
			rchk(IDX_FIFO[0], 8'h30 + 8'(i));
		// disabled hub endpoint ignores traffic
		u_host.out_pkt(3'd0, 1'b0, 8'h50, 2, 6'd4);
		rchk(IDX_FLG[0], 8'h00);
		rchk(IDX_LEN[0], 8'h1f);
		wr(IDX_IRQ_EN, 8'h06);
		wr(IDX_CFG[1], 8'h80);
		u_host.out_pkt(3'd1, 1'b0, 8'h10, 3, 6'd5);
		rchk(IDX_FLG[1], 8'h02);
		rchk(IDX_LEN[1], 8'h05);
		rchk(IDX_CFG[1], 8'h88);
		chk({27'h000_0000, nak}, 32'h0000_0002);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		rchk(IDX_FLG[0], 8'h00);
		// second out while full is refused, early setup is not
		u_host.out_pkt(3'd1, 1'b0, 8'h20, 3, 6'd7);
		rchk(IDX_LEN[1], 8'h05);
		rchk(IDX_FIFO[1], 8'h10);
		u_host.out_pkt(3'd1, 1'b1, 8'h40, 3, 6'd5);
		rchk(IDX_FLG[1], 8'h04);
		for (int i = 0; i < 3; i++)
			rchk(IDX_FIFO[1], 8'h40 + 8'(i));
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wr(IDX_CLR[1], 8'h04);
		rchk(IDX_FLG[1], 8'h00);
		rchk(IDX_CLR[1], 8'h00);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		u_host.ev(3'd1, 1'b1);
		rchk(IDX_FLG[1], 8'h08);
		wr(IDX_TXRDY, 8'h02);
		rchk(IDX_TXRDY, 8'h02);
		chk({27'h000_0000, txrdy}, 32'h0000_0002);
		u_host.ev(3'd1, 1'b0);
		rchk(IDX_TXRDY, 8'h00);
		chk({27'h000_0000, txrdy}, 32'h0000_0000);
		rchk(IDX_FLG[1], 8'h09);
		rchk(IDX_CFG[1], 8'h80);
		wr(IDX_CLR[1], 8'h08);
		rchk(IDX_FLG[1], 8'h01);
		wr(IDX_CLR[1], 8'h01);
		rchk(IDX_FLG[1], 8'h00);
		// oversized count saturates at the packet limit
		wr(IDX_CFG[2], 8'h82);
		u_host.out_pkt(3'd2, 1'b0, 8'h60, 8, 6'h3f);
		rchk(IDX_LEN[2], 8'h0a);
		chk({27'h000_0000, nak}, 32'h0000_0004);
		// all eight payload bytes come back in arrival order
		u_host.in_pkt(3'd2, 8, got);
		chk(got[31:0], 32'h6362_6160);
		chk(got[63:32], 32'h6766_6564);
		@(posedge core_clk) hub_in <= 6'h2b;
		repeat (2) @(posedge core_clk);
		chk({24'h00_0000, hub_byte}, 32'h0000_002b);
		stop_test();
	end

endmodule : tb
